//--- pkg/ddac_pkg.sv
// Shared constants for the dual DAC serial load port
package ddac_pkg;
  // Frame geometry
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned FCNT_W      = 5;
  localparam logic [4:0]  FCNT_LAST   = 5'h0F;      // Count value on the last edge
  localparam logic [4:0]  FCNT_DONE   = 5'h10;      // Saturated after a full frame
  localparam logic [4:0]  FCNT_RST    = 5'h00;
  // Control word field positions
  localparam int unsigned CH_BIT      = 15;         // 0 selects channel A, 1 channel B
  localparam int unsigned BUF_BIT     = 14;         // Reference buffer select
  localparam int unsigned PD_HI       = 13;
  localparam int unsigned PD_LO       = 12;
  localparam int unsigned DATA_W      = 12;         // Code field, bits 11:0
  // Values after reset
  localparam logic [11:0] DAC_RST     = 12'h000;
  localparam logic [1:0]  PD_RST      = 2'h0;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  // Buffering
  localparam int unsigned FIFO_DEPTH  = 8;
  // Host clock limit, kept for the checker side
  localparam int unsigned SCLK_MAX_HZ = 30000000;
endpackage : ddac_pkg

//--- hdl/ddac_serial_load_port.sv
// Serial load port, word FIFO and update logic of a dual DAC
`timescale 1ns/10ps

// Word FIFO between the serial link and the channel registers
module ddac_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(D);

  // Depth must be a power of two so pointers wrap cleanly
  generate
    if (D < 2 || (D & (D - 1)) != 0)
    begin : g_bad_depth
      $error("ddac_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage
    logic [AW:0]         wp;    // Write pointer, wrap bit on top
    logic [AW:0]         rp;    // Read pointer, wrap bit on top
  } ddac_fifo_st_t;

  ddac_fifo_st_t s_r;           // Registered state
  ddac_fifo_st_t s_nxt;         // Next state
  logic          full;          // No room left
  logic          empty;         // Nothing stored

  // Honest flags from the pointers
  assign full        = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
  assign empty       = (s_r.wp == s_r.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = s_r.mem[s_r.rp[AW-1:0]];

  // Push and pop
  always_comb
  begin
    s_nxt = s_r;
    if (in_valid_i && !full)
    begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
      s_nxt.wp                  = s_r.wp + 1'b1;
    end
    if (out_ready_i && !empty)
    begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule : ddac_fifo

module ddac_serial_load_port #(
  parameter int unsigned DEPTH = ddac_pkg::FIFO_DEPTH
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        sclk_i,
  input  wire logic        sync_n_i,
  input  wire logic        sdi_i,
  input  wire logic        load_update_n_i,
  output logic [11:0]      dac_a_o,
  output logic [11:0]      dac_b_o,
  output logic             ref_buf_a_o,
  output logic             ref_buf_b_o,
  output logic [1:0]       pd_a_o,
  output logic [1:0]       pd_b_o,
  output logic             buf_power_o,
  output logic             write_ready_o
);
  localparam int unsigned FW = ddac_pkg::FRAME_BITS;

  // Link side: shifter state, cleared whenever the frame closes
  typedef struct packed {
    logic [FW-1:0] shift;       // Bits taken so far
    logic [4:0]    cnt;         // Falling edges taken
  } ddac_shift_t;

  // Link side: finished word and its event toggle, kept across frames
  typedef struct packed {
    logic [FW-1:0] word;        // Last complete frame
    logic          tog;         // Flips once per complete frame
  } ddac_done_t;

  // System side state
  typedef struct packed {
    logic              tog_s1;  // Toggle synchroniser, first stage
    logic              tog_s2;  // Toggle synchroniser, second stage
    logic              tog_d;   // Previous toggle for edge detect
    logic              syn_s1;  // Frame sync synchroniser
    logic              syn_s2;
    logic              syn_d;
    logic              ld_s1;   // Load synchroniser
    logic              ld_s2;
    logic              pend_v;  // Word waiting for FIFO room
    logic [FW-1:0]     pend_w;
    logic              pwr;     // Input buffer power
    logic [1:0][11:0]  in_dat;  // Input registers
    logic [1:0]        in_buf;
    logic [1:0][1:0]   in_pd;
    logic [1:0]        fresh;   // Input register not yet loaded
    logic [1:0][11:0]  dac_dat; // DAC registers
    logic [1:0]        dac_buf;
    logic [1:0][1:0]   dac_pd;
  } ddac_sys_t;

  ddac_shift_t sh_r;            // Link shifter, registered
  ddac_shift_t sh_nxt;
  ddac_done_t  dn_r;            // Link result, registered
  ddac_done_t  dn_nxt;
  ddac_sys_t   s_r;             // System state, registered
  ddac_sys_t   s_nxt;
  logic        link_rst_n;      // Link shifter reset: power-on or frame closed
  logic        f_ready;         // FIFO room
  logic        f_valid;         // FIFO holds a word
  logic        f_pop;           // Drain takes the head word
  logic [FW-1:0] f_data;        // Head word
  logic        ch;              // Channel addressed by the head word

  // Frame sync high holds the shifter cleared; an early rise thus drops the frame
  assign link_rst_n = nrst_i & ~sync_n_i;

  // Shift on each falling edge until sixteen bits are in
  always_comb
  begin
    sh_nxt = sh_r;
    dn_nxt = dn_r;
    if (sh_r.cnt != ddac_pkg::FCNT_DONE)
    begin
      sh_nxt.shift = {sh_r.shift[FW-2:0], sdi_i};
      sh_nxt.cnt   = sh_r.cnt + 5'h01;
      if (sh_r.cnt == ddac_pkg::FCNT_LAST)
      begin
        dn_nxt.word = {sh_r.shift[FW-2:0], sdi_i};
        dn_nxt.tog  = ~dn_r.tog;
      end
    end
  end

  // Shifter runs only while the frame is open; clock may stop outside frames
  always_ff @(negedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sh_r.shift <= '0;
      sh_r.cnt   <= ddac_pkg::FCNT_RST;
    end
    else
    begin
      sh_r <= sh_nxt;
    end
  end

  // Result is held stable until the next full frame; read across domains
  always_ff @(negedge sclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dn_r.word <= ddac_pkg::WORD_RST;
      dn_r.tog  <= 1'b0;
    end
    else
    begin
      dn_r <= dn_nxt;
    end
  end

  ddac_fifo #(
    .W (FW),
    .D (DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (s_r.pend_v),
    .in_ready_o  (f_ready),
    .in_data_i   (s_r.pend_w),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );

  // Head word addresses one channel
  assign ch = f_data[ddac_pkg::CH_BIT];

  // Drain stalls one cycle when a copy is under way and the target channel holds a word not yet copied,
  // so during a copy no input register word is replaced before it reaches its DAC register
  assign f_pop = f_valid && !(!s_r.ld_s2 && s_r.fresh[ch]);

  // Room for a new frame: nothing pending and FIFO not full
  assign write_ready_o = !s_r.pend_v && f_ready;

  // Crossing, buffering and channel update
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.tog_s1 = dn_r.tog;
    s_nxt.tog_s2 = s_r.tog_s1;
    s_nxt.tog_d  = s_r.tog_s2;
    s_nxt.syn_s1 = sync_n_i;
    s_nxt.syn_s2 = s_r.syn_s1;
    s_nxt.syn_d  = s_r.syn_s2;
    s_nxt.ld_s1  = load_update_n_i;
    s_nxt.ld_s2  = s_r.ld_s1;
    // Buffers wake on the frame sync fall
    if (s_r.syn_d && !s_r.syn_s2)
    begin
      s_nxt.pwr = 1'b1;
    end
    // Buffers sleep when the frame completes or is abandoned
    if ((s_r.tog_s2 != s_r.tog_d) || s_r.syn_s2)
    begin
      s_nxt.pwr = 1'b0;
    end
    // Pending word moves into the FIFO when there is room
    if (s_r.pend_v && f_ready)
    begin
      s_nxt.pend_v = 1'b0;
    end
    // A finished frame becomes pending; a frame met by a full buffer is lost
    if ((s_r.tog_s2 != s_r.tog_d) && !(s_r.pend_v && !f_ready))
    begin
      s_nxt.pend_v = 1'b1;
      s_nxt.pend_w = dn_r.word;
    end
    // Load low: copy every channel into its DAC register
    for (int i = 0; i < 2; i++)
    begin
      if (!s_r.ld_s2)
      begin
        s_nxt.dac_dat[i] = s_r.in_dat[i];
        s_nxt.dac_buf[i] = s_r.in_buf[i];
        s_nxt.dac_pd[i]  = s_r.in_pd[i];
        s_nxt.fresh[i]   = 1'b0;
      end
    end
    // Head word lands in the addressed input register; new data wins
    if (f_pop)
    begin
      s_nxt.in_dat[ch] = f_data[ddac_pkg::DATA_W-1:0];
      s_nxt.in_buf[ch] = f_data[ddac_pkg::BUF_BIT];
      s_nxt.in_pd[ch]  = f_data[ddac_pkg::PD_HI:ddac_pkg::PD_LO];
      s_nxt.fresh[ch]  = 1'b1;
    end
  end

  // System register; DAC registers change only through the load copy
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r        <= '0;
      s_r.syn_s1 <= 1'b1;
      s_r.syn_s2 <= 1'b1;
      s_r.syn_d  <= 1'b1;
      s_r.ld_s1  <= 1'b1;
      s_r.ld_s2  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from registers
  assign dac_a_o     = s_r.dac_dat[0];
  assign dac_b_o     = s_r.dac_dat[1];
  assign ref_buf_a_o = s_r.dac_buf[0];
  assign ref_buf_b_o = s_r.dac_buf[1];
  assign pd_a_o      = s_r.dac_pd[0];
  assign pd_b_o      = s_r.dac_pd[1];
  assign buf_power_o = s_r.pwr;
endmodule : ddac_serial_load_port

//--- verification/ddac_port_asserts.sv
// Port-level assertions for the dual DAC serial load port
`timescale 1ns/10ps
module ddac_port_asserts (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        sclk_i,
  input wire logic        sync_n_i,
  input wire logic        sdi_i,
  input wire logic        load_update_n_i,
  input wire logic [11:0] dac_a_o,
  input wire logic [11:0] dac_b_o,
  input wire logic        ref_buf_a_o,
  input wire logic        ref_buf_b_o,
  input wire logic [1:0]  pd_a_o,
  input wire logic [1:0]  pd_b_o,
  input wire logic        buf_power_o,
  input wire logic        write_ready_o
);
  // Both DAC registers seen as one bundle
  wire [29:0] dreg = {dac_a_o, dac_b_o, ref_buf_a_o, ref_buf_b_o, pd_a_o, pd_b_o};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Load high long enough to pass the two-flop synchroniser
  sequence load_idle_s; load_update_n_i[*4]; endsequence
  sequence frame_open_s; $fell(sync_n_i); endsequence
  dac_hold_a: assert property (load_idle_s |=> $stable(dreg))
    else $error("DAC moved with load high");
  dac_cause_a: assert property ($changed(dreg) |-> !$past(load_update_n_i, 2)
    || !$past(load_update_n_i, 3)) else $error("DAC moved without load");
  buf_wake_a: assert property (frame_open_s |-> ##[1:5] buf_power_o)
    else $error("Buffers not powered");
  buf_cause_a: assert property ($rose(buf_power_o) |-> !$past(sync_n_i))
    else $error("Buffers woke without sync");
  buf_sleep_a: assert property (sync_n_i[*6] |-> !buf_power_o)
    else $error("Buffers on while idle");
  ready_idle_a: assert property (sync_n_i[*8] |-> write_ready_o)
    else $error("No room while idle");
  ready_reset_a: assert property ($rose(nrst_i) |-> write_ready_o && !buf_power_o)
    else $error("Bad state after reset");
  // Reset must clear outputs, so this one is not disabled by it
  reset_vals_a: assert property (disable iff (1'b0) !nrst_i |-> dreg == 30'h0)
    else $error("DAC not cleared in reset");
endmodule : ddac_port_asserts

bind ddac_serial_load_port ddac_port_asserts ddac_port_asserts_inst (.*);

//--- verification/ddac_host_model.sv
// Behavioural host serial master for the load port
`timescale 1ns/10ps
module ddac_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o
);
  // Clock parks high so each edge in a frame starts with a fall
  initial
  begin
    sclk_o   = 1'b1;
    sdi_o    = 1'b0;
    // Sync settles an instant late so the shifter's clear sees a real fall
    #1;
    sync_n_o = 1'b1;
  end
  // One frame; edges past sixteen carry ones, fewer aborts it
  task automatic send(input logic [15:0] word, input int edges, input realtime half);
    #3;                                       // Link phase off the system clock edges
    sync_n_o = 1'b0;
    for (int i = 0; i < edges; i++)
    begin
      sdi_o = (i < 16) ? word[15 - i] : 1'b1; // MSB first
      #(half) sclk_o = 1'b0;                  // Sample edge
      #(half) sclk_o = 1'b1;                  // Half period sets rate
    end
    sync_n_o = 1'b1;
    sdi_o    = ~sdi_o;                        // Released line shows no stale bit
    #100;                                     // Minimum sync high time
  endtask : send
endmodule : ddac_host_model

//--- verification/ddac_serial_load_port_bench.sv
// Self-checking bench for the dual DAC serial load port
`timescale 1ns/10ps
module ddac_serial_load_port_bench;
  logic        clock_i;       // System clock
  logic        nrst_i;        // Async reset
  logic        load_update_n; // Load strobe
  logic        sclk;          // Link lines from host
  logic        sync_n;
  logic        sdi;
  logic [11:0] dac_a;         // Channel outputs
  logic [11:0] dac_b;
  logic        ref_a;
  logic        ref_b;
  logic [1:0]  pd_a;
  logic [1:0]  pd_b;
  logic        buf_pwr;
  logic        wr_rdy;
  int          error_cnt;     // Mismatches
  int          compares;      // Comparisons
  // System clock
  always #5 clock_i = ~clock_i;
  ddac_serial_load_port #(.DEPTH(8)) ddac_serial_load_port_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi),
    .load_update_n_i(load_update_n), .dac_a_o(dac_a), .dac_b_o(dac_b), .ref_buf_a_o(ref_a),
    .ref_buf_b_o(ref_b), .pd_a_o(pd_a), .pd_b_o(pd_b), .buf_power_o(buf_pwr),
    .write_ready_o(wr_rdy));
  ddac_host_model ddac_host_model_inst (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  // Verdict, also reached by a spent bound
  task automatic end_of_test();
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Load low for three cycles, then settle
  task automatic pulse_load();
    load_update_n <= 1'b0;
    cyc(3);
    load_update_n <= 1'b1;
    cyc(4);
  endtask : pulse_load
  // Reset, also reused after the last test
  task automatic t_reset();
    nrst_i <= 1'b0;
    cyc(5);
    // Outputs are read on the falling edge, away from the edge that moves them
    @(negedge clock_i);
    chk("chan_a", {1'b0, ref_a, pd_a, dac_a}, 16'h0000);
    chk("chan_b", {1'b0, ref_b, pd_b, dac_b}, 16'h0000);
    cyc(1);
    nrst_i <= 1'b1;
    cyc(3);
    @(negedge clock_i);
    chk("ready", {14'h0, wr_rdy, buf_pwr}, 16'h0002);
  endtask : t_reset
  // Writes held back until load, then both channels move
  task automatic t_hold();
    fork
      ddac_host_model_inst.send(16'h4ABC, 16, 7.5);
      begin
        cyc(12);
        @(negedge clock_i);
        chk("power", {15'h0, buf_pwr}, 16'h0001);
      end
    join
    ddac_host_model_inst.send(16'hA123, 16, 7.5);
    cyc(20);
    @(negedge clock_i);
    chk("held_a", {4'h0, dac_a}, 16'h0000);
    chk("power", {15'h0, buf_pwr}, 16'h0000);
    cyc(1);
    pulse_load();
    @(negedge clock_i);
    chk("chan_a", {1'b0, ref_a, pd_a, dac_a}, 16'h4ABC);
    chk("chan_b", {1'b0, ref_b, pd_b, dac_b}, 16'h2123);
  endtask : t_hold
  // Aborted frame, then a frame with surplus edges
  task automatic t_abort();
    ddac_host_model_inst.send(16'h4555, 15, 7.5);
    ddac_host_model_inst.send(16'h800F, 20, 7.5);
    cyc(20);
    pulse_load();
    @(negedge clock_i);
    chk("abort_a", {1'b0, ref_a, pd_a, dac_a}, 16'h4ABC);
    chk("extra_b", {1'b0, ref_b, pd_b, dac_b}, 16'h000F);
  endtask : t_abort
  // Load held low makes the copy transparent
  task automatic t_transp();
    int n = 0;
    cyc(1);
    load_update_n <= 1'b0;
    ddac_host_model_inst.send(16'h0FFF, 16, 7.5);
    cyc(1);
    while (dac_a !== 12'hFFF && n < 40)
    begin
      cyc(1);
      n++;
    end
    // A spent bound is a mismatch and ends the run
    if (n == 40)
    begin
      error_cnt++;
      end_of_test();
    end
    @(negedge clock_i);
    chk("live_a", {1'b0, ref_a, pd_a, dac_a}, 16'h0FFF);
    chk("keep_b", {4'h0, dac_b}, 16'h000F);
    cyc(1);
    load_update_n <= 1'b1;
    cyc(4);
  endtask : t_transp
  // Hang guard
  initial
  begin
    cyc(20000);
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    clock_i = 1'b0;
    // High for an instant so the asynchronous reset starts with a real fall
    nrst_i = 1'b1;
    load_update_n = 1'b1;
    error_cnt = 0;
    compares = 0;
    #1;
    nrst_i = 1'b0;
    @(posedge clock_i);
    t_reset();
    t_hold();
    t_abort();
    t_transp();
    t_reset();
    end_of_test();
  end
endmodule : ddac_serial_load_port_bench
